// *** rtl/wake_frame_mask_and_length_cfg.sv ***
// selective-wake identifier mask and frame length code registers with frame matcher
// Operation
// - identifier bits 12..0 are compared when their mask bit is one and the bit lies inside the identifier width
// - mask bit zero makes the identifier bit a don't care
// - low mask: id 12..5 at bits 15..8, id 4..0 at bits 6..2
// - reserved bits read zero: low mask 7 and 1..0, length 15..4
// - power-on/soft reset clears low mask; restart keeps mask, zeroes reserved
// - restart keeps length code, upper twelve bits zero; reset clears all
// - length code is four read-write bits 3..0; codes 0..7 mean bytes
// - codes 8..15 mean eight bytes, the largest data field
// - received length code must equal configured code bit by bit
// - extension flag picks 11-bit or 29-bit identifiers for the mask
// - companion register masks identifier bits 28..13, same encoding
`timescale 1ns/100ps
`default_nettype none
module wake_frame_mask_and_length_cfg (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // reset sources
  input  wire logic        soft_reset_i,
  input  wire logic        restart_i,
  // register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [6:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  // received frame from the bus decoder, with the configured identifier and extension flag
  input  wire logic        frame_valid_i,
  input  wire logic        frame_extended_i,
  input  wire logic [28:0] frame_id_i,
  input  wire logic [28:0] cfg_id_i,
  input  wire logic        cfg_extended_i,
  input  wire logic [3:0]  frame_length_code_i,
  // match result and the byte count of the configured length code
  output logic             match_done_o,
  output logic             match_hit_o,
  output logic      [3:0]  payload_bytes_o
);
  // configuration registers as seen on the read port
  logic [15:0] id_low_mask_reg;
  logic [15:0] id_high_mask_reg;
  logic [15:0] length_code_reg;

  // writes need no acknowledge; a write to any other address changes nothing here
  wire wr_low  = reg_wr_i && (reg_addr_i == wake_cfg_pkg::ADDR_ID_LOW_MASK);
  wire wr_high = reg_wr_i && (reg_addr_i == wake_cfg_pkg::ADDR_ID_HIGH_MASK);
  wire wr_len  = reg_wr_i && (reg_addr_i == wake_cfg_pkg::ADDR_LENGTH_CODE);

  // low mask: reserved bits 7 and 1..0 never store a one
  wake_cfg_reg #(
    .RW_MASK   (wake_cfg_pkg::ID_LOW_MASK_RW),
    .RST_VALUE (wake_cfg_pkg::ID_LOW_MASK_RST)
  ) u_low_mask (
    .clk_sys_i    (clk_sys_i),
    .rst_b_i      (rst_b_i),
    .soft_reset_i (soft_reset_i),
    .restart_i    (restart_i),
    .wr_en_i      (wr_low),
    .wr_data_i    (reg_wdata_i),
    .value_o      (id_low_mask_reg)
  );

  // high mask: all sixteen bits are writable
  wake_cfg_reg #(
    .RW_MASK   (wake_cfg_pkg::ID_HIGH_MASK_RW),
    .RST_VALUE (wake_cfg_pkg::ID_HIGH_MASK_RST)
  ) u_high_mask (
    .clk_sys_i    (clk_sys_i),
    .rst_b_i      (rst_b_i),
    .soft_reset_i (soft_reset_i),
    .restart_i    (restart_i),
    .wr_en_i      (wr_high),
    .wr_data_i    (reg_wdata_i),
    .value_o      (id_high_mask_reg)
  );

  // length: only the four code bits are stored
  wake_cfg_reg #(
    .RW_MASK   (wake_cfg_pkg::LENGTH_CODE_RW),
    .RST_VALUE (wake_cfg_pkg::LENGTH_CODE_RST)
  ) u_length (
    .clk_sys_i    (clk_sys_i),
    .rst_b_i      (rst_b_i),
    .soft_reset_i (soft_reset_i),
    .restart_i    (restart_i),
    .wr_en_i      (wr_len),
    .wr_data_i    (reg_wdata_i),
    .value_o      (length_code_reg)
  );

  // read select; unmapped addresses return zero
  wire        rd_sel_low  = (reg_addr_i == wake_cfg_pkg::ADDR_ID_LOW_MASK);
  wire        rd_sel_high = (reg_addr_i == wake_cfg_pkg::ADDR_ID_HIGH_MASK);
  wire        rd_sel_len  = (reg_addr_i == wake_cfg_pkg::ADDR_LENGTH_CODE);
  // and-or mux: the selects are exclusive, so no priority chain is needed
  wire [15:0] rd_mux      = ({16{rd_sel_low}}  & id_low_mask_reg)  |
                            ({16{rd_sel_high}} & id_high_mask_reg) |
                            ({16{rd_sel_len}}  & length_code_reg);
  // the data word falls back to zero between reads so a stale word never lingers
  wire [15:0] next_rdata  = reg_rd_i ? rd_mux : 16'h0000;

  // gather the 29-bit compare mask from both registers
  // the low register skips bit 7, so its two fields are cut apart here
  wire [15:0] mask_id_28_13 = id_high_mask_reg;
  wire [7:0]  mask_id_12_5  = id_low_mask_reg[15:wake_cfg_pkg::ID_UPPER_POS];
  wire [4:0]  mask_id_4_0   = id_low_mask_reg[6:wake_cfg_pkg::ID_LOWER_POS];
  wire [28:0] id_mask       = {mask_id_28_13, mask_id_12_5, mask_id_4_0};

  // standard frames carry only 11 identifier bits; the upper bits never reach the compare
  wire [28:0] id_width_mask = cfg_extended_i ? 29'h1FFFFFFF :
                              {18'h00000, {wake_cfg_pkg::STD_ID_BITS{1'b1}}};

  // per bit: a cleared mask bit accepts anything
  // a bit is compared only when its mask bit is set and it lies inside the identifier width
  logic [28:0] id_bit_ok;
  genvar gi;
  generate
    for (gi = 0; gi < 29; gi++) begin : g_id_cmp
      wire bit_compared = id_mask[gi] && id_width_mask[gi];
      wire bit_equal    = (frame_id_i[gi] == cfg_id_i[gi]);
      assign id_bit_ok[gi] = !bit_compared || bit_equal;
    end
  endgenerate

  // the frame matches only when every part agrees
  wire       id_ok       = &id_bit_ok;
  // a standard frame never matches an extended configuration or the reverse
  wire       ext_ok      = (frame_extended_i == cfg_extended_i);
  // the full code is compared, so two codes that both mean eight bytes still differ
  wire [3:0] length_code = length_code_reg[3:0];
  wire       length_ok   = (frame_length_code_i == length_code);
  wire       hit_now     = id_ok && ext_ok && length_ok;

  // length code to byte count, saturating at eight
  // codes above eight are legal and simply mean a full data field
  wire       length_saturates   = (length_code > wake_cfg_pkg::LENGTH_MAX_BYTES);
  wire [3:0] next_payload_bytes = length_saturates ? wake_cfg_pkg::LENGTH_MAX_BYTES : length_code;

  // the frame is sampled in ST_IDLE and judged against the registers of that cycle,
  // so a register write that lands later only affects the following frame
  // frames offered during compare or done are dropped; the sender must space them
  wake_cfg_pkg::match_state_t state;
  wake_cfg_pkg::match_state_t next_state;
  logic                       next_hit;
  logic                       hit_q;

  // next state and the verdict latched when a frame is taken
  always_comb begin
    next_state = state;
    next_hit   = hit_q;
    case (state)
      wake_cfg_pkg::ST_IDLE: begin
        // only an idle matcher takes a frame
        if (frame_valid_i) begin
          next_state = wake_cfg_pkg::ST_COMPARE;
          next_hit   = hit_now;
        end
      end
      wake_cfg_pkg::ST_COMPARE: begin
        // the verdict is decoded here and reaches the outputs one cycle later, in ST_DONE
        next_state = wake_cfg_pkg::ST_DONE;
      end
      wake_cfg_pkg::ST_DONE: begin
        // one dead cycle keeps the result pulse apart from the next frame
        next_state = wake_cfg_pkg::ST_IDLE;
      end
      default: begin
        // an unused code can only come from a disturbance; recover to idle
        next_state = wake_cfg_pkg::ST_IDLE;
      end
    endcase
  end

  // result outputs are decoded from the state, so they stand for exactly one cycle
  // the hit flag is only meaningful alongside done, so it is gated here as well
  wire next_match_done = (state == wake_cfg_pkg::ST_COMPARE);
  wire next_match_hit  = next_match_done && hit_q;

  // matcher state and the verdict captured with the frame
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= wake_cfg_pkg::ST_IDLE;
      hit_q <= 1'b0;
    end else begin
      state <= next_state;
      hit_q <= next_hit;
    end
  end

  // match result flops
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      match_done_o <= 1'b0;
      match_hit_o  <= 1'b0;
    end else begin
      match_done_o <= next_match_done;
      match_hit_o  <= next_match_hit;
    end
  end

  // byte count follows the configured code one cycle later
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      payload_bytes_o <= 4'h0;
    end else begin
      payload_bytes_o <= next_payload_bytes;
    end
  end

  // read data is registered so the port never shows a combinational path from the address
  // a reader must therefore take the word one cycle after its strobe
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end
endmodule : wake_frame_mask_and_length_cfg
`default_nettype wire

// *** rtl/wake_cfg_pkg.sv ***
// constants for the selective-wake mask and length configuration block
package wake_cfg_pkg;
  // register addresses on the 7-bit serial register port
  localparam logic [6:0]  ADDR_ID_HIGH_MASK = 7'h34;
  localparam logic [6:0]  ADDR_ID_LOW_MASK  = 7'h35;
  localparam logic [6:0]  ADDR_LENGTH_CODE  = 7'h36;
  // writable bit patterns
  localparam logic [15:0] ID_LOW_MASK_RW    = 16'hFF7C;
  localparam logic [15:0] ID_HIGH_MASK_RW   = 16'hFFFF;
  localparam logic [15:0] LENGTH_CODE_RW    = 16'h000F;
  // field positions in the low mask register
  localparam int          ID_UPPER_POS      = 8;
  localparam int          ID_LOWER_POS      = 2;
  // values after power-on or soft reset
  localparam logic [15:0] ID_LOW_MASK_RST   = 16'h0000;
  localparam logic [15:0] ID_HIGH_MASK_RST  = 16'h0000;
  localparam logic [15:0] LENGTH_CODE_RST   = 16'h0000;
  // length decode and standard identifier width
  localparam logic [3:0]  LENGTH_MAX_BYTES  = 4'h8;
  localparam int          STD_ID_BITS       = 11;
  // matcher states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_COMPARE = 3'b010,
    ST_DONE    = 3'b100
  } match_state_t;
endpackage : wake_cfg_pkg

// *** rtl/wake_cfg_reg.sv ***
// one configuration register with write mask, restart scrub and power-on clear
`timescale 1ns/100ps
`default_nettype none
module wake_cfg_reg #(
  parameter logic [15:0] RW_MASK   = 16'hFFFF,
  parameter logic [15:0] RST_VALUE = 16'h0000
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // control
  input  wire logic        soft_reset_i,
  input  wire logic        restart_i,
  input  wire logic        wr_en_i,
  input  wire logic [15:0] wr_data_i,
  // content
  output logic      [15:0] value_o
);
  logic [15:0] value;
  logic [15:0] next_value;

  // restart keeps writable bits and scrubs reserved ones; writes never touch reserved bits
  assign next_value = soft_reset_i ? RST_VALUE :
                      wr_en_i      ? (wr_data_i & RW_MASK) :
                      restart_i    ? (value & RW_MASK) : value;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      value <= RST_VALUE;
    end else begin
      value <= next_value;
    end
  end

  assign value_o = value;
endmodule : wake_cfg_reg
`default_nettype wire

// *** bench/wake_cfg_props.sv ***
// port assertions for the wake mask and length block
`timescale 1ns/100ps
`default_nettype none
module wake_cfg_props (
  // watched ports
  input wire logic        clk_sys_i,
  input wire logic        rst_b_i,
  input wire logic        soft_reset_i,
  input wire logic        reg_rd_i,
  input wire logic [6:0]  reg_addr_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        frame_valid_i,
  input wire logic        match_done_o,
  input wire logic        match_hit_o,
  input wire logic [3:0]  payload_bytes_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  property p_lat; match_done_o |-> $past(frame_valid_i, 2); endproperty
  a_lat: assert property (p_lat) else $error("late done");
  property p_hit; match_hit_o |-> match_done_o; endproperty
  a_hit: assert property (p_hit) else $error("stray hit");
  property p_pulse; match_done_o |=> !match_done_o; endproperty
  a_pulse: assert property (p_pulse) else $error("long done");
  property p_low; reg_rd_i && reg_addr_i == 7'h35 |=> reg_rdata_o[7] == 1'h0 && reg_rdata_o[1:0] == 2'h0; endproperty
  a_low: assert property (p_low) else $error("low reserved");
  property p_len; reg_rd_i && reg_addr_i == 7'h36 |=> reg_rdata_o[15:4] == 12'h000; endproperty
  a_len: assert property (p_len) else $error("length reserved");
  property p_soft; soft_reset_i ##1 reg_rd_i |=> reg_rdata_o == 16'h0000; endproperty
  a_soft: assert property (p_soft) else $error("soft clear");
  property p_sat; payload_bytes_o <= 4'h8; endproperty
  a_sat: assert property (p_sat) else $error("payload");
  property p_unmap; reg_rd_i && reg_addr_i > 7'h36 |=> reg_rdata_o == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
endmodule : wake_cfg_props
bind wake_frame_mask_and_length_cfg wake_cfg_props props (.clk_sys_i, .rst_b_i, .soft_reset_i, .reg_rd_i,
  .reg_addr_i, .reg_rdata_o, .frame_valid_i, .match_done_o, .match_hit_o, .payload_bytes_o);
`default_nettype wire

// *** bench/wake_node_model.sv ***
// bus node model handing received wake-up frames to the matcher
`timescale 1ns/100ps
`default_nettype none
module wake_node_model (
  // clock
  input  wire logic        clk_sys_i,
  // received frame
  output var  logic        frame_valid_o = 1'h0,
  output var  logic        frame_extended_o = 1'h0,
  output var  logic [28:0] frame_id_o = 29'h0,
  output var  logic [3:0]  frame_length_code_o = 4'h0
);
  // fields invert after the valid beat so a late capture cannot match by luck
  task automatic send(input logic [28:0] id, input logic ext, input logic [3:0] len);
    @(posedge clk_sys_i)
      {frame_valid_o, frame_extended_o, frame_id_o, frame_length_code_o} <= {1'h1, ext, id, len};
    @(posedge clk_sys_i)
      {frame_valid_o, frame_extended_o, frame_id_o, frame_length_code_o} <= {1'h0, ~ext, ~id, ~len};
  endtask : send
endmodule : wake_node_model
`default_nettype wire

// *** bench/wake_frame_mask_and_length_cfg_test.sv ***
// self-checking bench for the wake mask and length block
`timescale 1ns/100ps
`default_nettype none
module wake_frame_mask_and_length_cfg_test;
  logic        clk_sys_i = 1'h0, rst_b_i = 1'h0, soft_reset_i = 1'h0, restart_i = 1'h0, reg_wr_i = 1'h0;
  logic        reg_rd_i = 1'h0, cfg_extended_i = 1'h1, frame_valid_i, frame_extended_i, match_done_o, match_hit_o;
  logic [6:0]  reg_addr_i = 7'h00;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
  logic [28:0] cfg_id_i = 29'h0, frame_id_i;
  logic [3:0]  frame_length_code_i, payload_bytes_o;
  int          failures = 0, cmp_count = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  wake_frame_mask_and_length_cfg dut (.clk_sys_i, .rst_b_i, .soft_reset_i, .restart_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .frame_valid_i, .frame_extended_i, .frame_id_i, .cfg_id_i,
    .cfg_extended_i, .frame_length_code_i, .match_done_o, .match_hit_o, .payload_bytes_o);
  wake_node_model node (.clk_sys_i, .frame_valid_o(frame_valid_i), .frame_extended_o(frame_extended_i),
    .frame_id_o(frame_id_i), .frame_length_code_o(frame_length_code_i));
  task automatic chk(input string what, input logic [15:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // a read carries its expected word in d
  task automatic acc(input logic wr, input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_sys_i) {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {wr, !wr, a, d};
    @(posedge clk_sys_i) {reg_wr_i, reg_rd_i} <= 2'h0;
    #1 if (!wr) chk("rdata", d, reg_rdata_o);
  endtask : acc
  task automatic frame(input logic [28:0] id, input logic ext, input logic [3:0] len, input logic hit);
    node.send(id, ext, len);
    repeat (4) if (match_done_o !== 1'h1) @(posedge clk_sys_i) #1;
    chk("done", 16'h0001, 16'(match_done_o));
    if (match_done_o !== 1'h1) tally_and_finish();
    chk("hit", 16'(hit), 16'(match_hit_o));
  endtask : frame
  task automatic t_registers;
    acc(1'h0, 7'h35, 16'h0000);
    acc(1'h1, 7'h35, 16'hFFFF);
    acc(1'h0, 7'h35, 16'hFF7C);
    acc(1'h1, 7'h36, 16'hFFFF);
    acc(1'h0, 7'h36, 16'h000F);
    acc(1'h0, 7'h37, 16'h0000);
    acc(1'h1, 7'h34, 16'hFFFF);
    acc(1'h0, 7'h34, 16'hFFFF);
    @(posedge clk_sys_i) restart_i <= 1'h1;
    @(posedge clk_sys_i) restart_i <= 1'h0;
    acc(1'h0, 7'h36, 16'h000F);
    acc(1'h0, 7'h35, 16'hFF7C);
    @(posedge clk_sys_i) soft_reset_i <= 1'h1;
    acc(1'h0, 7'h35, 16'h0000);
    acc(1'h0, 7'h36, 16'h0000);
    acc(1'h0, 7'h34, 16'h0000);
    @(posedge clk_sys_i) soft_reset_i <= 1'h0;
    $display("register test done");
  endtask : t_registers
  task automatic t_match;
    acc(1'h1, 7'h35, 16'h8000);
    acc(1'h1, 7'h36, 16'h0003);
    frame(29'h0, 1'h1, 4'h3, 1'h1);
    frame(29'h1000, 1'h1, 4'h3, 1'h0);
    frame(29'h800, 1'h1, 4'h3, 1'h1);
    frame(29'h0, 1'h1, 4'hB, 1'h0);
    frame(29'h0, 1'h0, 4'h3, 1'h0);
    $display("match test done");
  endtask : t_match
  // high mask bit 28 and low mask bit 0 against a non-zero configured identifier
  task automatic t_ext;
    acc(1'h1, 7'h34, 16'h8000);
    acc(1'h1, 7'h35, 16'h0004);
    @(posedge clk_sys_i) cfg_id_i <= 29'h10000001;
    frame(29'h10000001, 1'h1, 4'h3, 1'h1);
    frame(29'h00000001, 1'h1, 4'h3, 1'h0);
    frame(29'h10000000, 1'h1, 4'h3, 1'h0);
    @(posedge clk_sys_i) cfg_extended_i <= 1'h0;
    frame(29'h00000001, 1'h0, 4'h3, 1'h1);
    frame(29'h00000000, 1'h0, 4'h3, 1'h0);
    $display("extended identifier test done");
  endtask : t_ext
  task automatic t_codes;
    for (int c = 0; c < 16; c++) begin
      acc(1'h1, 7'h36, 16'(c));
      @(posedge clk_sys_i) #1 chk("payload", (c > 7) ? 16'h0008 : 16'(c), 16'(payload_bytes_o));
    end
    frame(29'h00000001, 1'h0, 4'h8, 1'h0);
    frame(29'h00000001, 1'h0, 4'hF, 1'h1);
    $display("length code test done");
  endtask : t_codes
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_b_i <= 1'h1;
    t_registers();
    t_match();
    t_ext();
    t_codes();
    tally_and_finish();
  end
endmodule : wake_frame_mask_and_length_cfg_test
`default_nettype wire
